// ### include/swr_cfg.svh
// Register offsets, field positions, reset values and timing counts of the sleep/wake block
`ifndef SWR_CFG_SVH
`define SWR_CFG_SVH

`define SWR_ADDR_W 4
`define SWR_DATA_W 8

`define SWR_OFF_STATUS 4'h0
`define SWR_OFF_CTRL 4'h1
`define SWR_OFF_PORT 4'h2
`define SWR_OFF_IRQ_STAT 4'h3
`define SWR_OFF_IRQ_EN 4'h4
`define SWR_OFF_IRQ_CLR 4'h5

`define SWR_ST_PIN_WAKE 7
`define SWR_ST_CMP_WAKE 6
`define SWR_ST_TIMEOUT 4
`define SWR_ST_POWERDOWN 3

`define SWR_CT_WDT_EN 0
`define SWR_CT_EXTERNAL_RESET_PIN_N_EN 1
`define SWR_CT_PIN_WAKE_EN 2
`define SWR_CT_CMP_WAKE_EN 3
`define SWR_CT_PSA_WDT 4
`define SWR_CT_PS_LSB 5

`define SWR_IRQ_WAKE 0
`define SWR_IRQ_WDT 1
`define SWR_IRQ_EXTERNAL_RESET_PIN_N 2

`define SWR_CTRL_RST 8'hF3
`define SWR_PORT_RST 8'h70
`define SWR_IRQ_EN_RST 3'h0
`define SWR_SYNC_RST 5'h10

`define SWR_CLK_MHZ 250
`define SWR_DRT_NS 10000
`define SWR_DRT_CYC ((`SWR_DRT_NS * `SWR_CLK_MHZ + 999) / 1000)
`define SWR_WDT_US 18000
`define SWR_WDT_CYC (`SWR_WDT_US * `SWR_CLK_MHZ)

`endif

// ### include/swr_pkg.sv
// Types shared by the sleep/wake block
package swr_pkg;

    typedef enum logic [1:0] {
        SWR_RUN = 2'b00,
        SWR_SLEEP = 2'b01,
        SWR_RESET = 2'b10
    } swr_state_t;

    typedef enum logic [2:0] {
        SWR_C_NONE = 3'b000,
        SWR_C_EXTERNAL_RESET_PIN_N = 3'b001,
        SWR_C_WDT = 3'b010,
        SWR_C_PIN = 3'b011,
        SWR_C_CMP = 3'b100
    } swr_cause_t;

endpackage

// ### verilog/swr_sleep_wake.sv
// Sleep entry, wake-up, watchdog and reset-cause flags of a small controller
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ns
`include "swr_cfg.svh"
module swr_sleep_wake #(
    parameter int unsigned WDT_PERIOD_CYC = `SWR_WDT_CYC
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [`SWR_ADDR_W-1:0] regAddr,
    input wire logic [`SWR_DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [`SWR_DATA_W-1:0] regRdData,
    input wire logic sleepExec,
    input wire logic portAccess,
    input wire logic external_reset_pin_n,
    input wire logic port_pin0,
    input wire logic port_pin1,
    input wire logic port_pin3,
    input wire logic comparatorOut,
    output logic [2:0] portOut,
    output logic [2:0] portOeN,
    output logic cpuReset,
    output logic mainClkEn,
    output swr_pkg::swr_state_t powerState,
    output logic irq
);
    import swr_pkg::*;

    localparam logic [11:0] DRT_LOAD = 12'(`SWR_DRT_CYC - 1);
    localparam logic [22:0] WDT_LAST = 23'(WDT_PERIOD_CYC - 1);

    function automatic logic hit(
        input logic [`SWR_ADDR_W-1:0] addr,
        input logic [`SWR_ADDR_W-1:0] off
    );
        hit = (addr == off);
    endfunction

    logic [4:0] meta_q;
    logic [4:0] syncd_q;
    logic [7:0] ctrl_q;
    logic [7:0] port_q;
    logic [2:0] irqStat_q;
    logic [2:0] irqStat_d;
    logic [2:0] irqEn_q;
    logic [2:0] pinRef_q;
    logic cmpRef_q;
    logic [22:0] watchdog_counter_q;
    logic [6:0] pre_q;
    logic [6:0] preMax;
    logic [11:0] rstCnt_q;
    logic timeout_flag_n_q;
    logic powerdown_flag_n_q;
    logic pin_wake_flag_q;
    logic comparator_wake_flag_q;
    swr_state_t state_q;
    swr_state_t state_d;
    swr_cause_t cause;
    logic [2:0] pinsNow;
    logic cmpNow;
    logic mclrLow;
    logic baseDone;
    logic preDone;
    logic wdtFire;
    logic sleepGo;
    logic wdtClr;
    logic wrCtrl;
    logic wrPort;
    logic wrIrqEn;
    logic wrIrqClr;

    // Pins and comparator arrive from outside the clock domain
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= `SWR_SYNC_RST;
            syncd_q <= `SWR_SYNC_RST;
        end else begin
            meta_q <= {external_reset_pin_n, comparatorOut, port_pin3, port_pin1, port_pin0};
            syncd_q <= meta_q;
        end
    end

    assign pinsNow = syncd_q[2:0];
    assign cmpNow = syncd_q[3];
    // Pin acts as reset only when given that role
    assign mclrLow = ctrl_q[`SWR_CT_EXTERNAL_RESET_PIN_N_EN] & ~syncd_q[4];

    assign wrCtrl = regWr & hit(regAddr, `SWR_OFF_CTRL);
    assign wrPort = regWr & hit(regAddr, `SWR_OFF_PORT);
    assign wrIrqEn = regWr & hit(regAddr, `SWR_OFF_IRQ_EN);
    assign wrIrqClr = regWr & hit(regAddr, `SWR_OFF_IRQ_CLR);

    // Watchdog period chain: base count, then optional prescaler
    assign preMax = 7'(8'(8'h01 << ctrl_q[`SWR_CT_PS_LSB +: 3]) - 8'h01);
    assign baseDone = (watchdog_counter_q == WDT_LAST);
    assign preDone = ~ctrl_q[`SWR_CT_PSA_WDT] | (pre_q == preMax);
    assign wdtFire = ctrl_q[`SWR_CT_WDT_EN] & baseDone & preDone & (state_q != SWR_RESET);

    // Reset cause; the pin outranks the watchdog, sleep wakes come last
    always_comb begin
        cause = SWR_C_NONE;
        if (state_q != SWR_RESET) begin
            if (mclrLow) begin
                cause = SWR_C_EXTERNAL_RESET_PIN_N;
            end else if (wdtFire) begin
                cause = SWR_C_WDT;
            end else if (state_q == SWR_SLEEP && ctrl_q[`SWR_CT_PIN_WAKE_EN]
                         && pinsNow != pinRef_q) begin
                cause = SWR_C_PIN;
            end else if (state_q == SWR_SLEEP && ctrl_q[`SWR_CT_CMP_WAKE_EN]
                         && cmpNow != cmpRef_q) begin
                cause = SWR_C_CMP;
            end
        end
    end

    assign sleepGo = (state_q == SWR_RUN) & sleepExec & (cause == SWR_C_NONE);
    // Cleared on sleep entry, on any wake and while the core is held in reset
    assign wdtClr = sleepGo | (state_q == SWR_SLEEP && cause != SWR_C_NONE)
                    | (state_q == SWR_RESET);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SWR_RUN: begin
                if (cause != SWR_C_NONE) begin
                    state_d = SWR_RESET;
                end else if (sleepExec) begin
                    state_d = SWR_SLEEP;
                end
            end
            SWR_SLEEP: begin
                if (cause != SWR_C_NONE) begin
                    state_d = SWR_RESET;
                end
            end
            SWR_RESET: begin
                if (!mclrLow && rstCnt_q == 12'h000) begin
                    state_d = SWR_RUN;
                end
            end
            default: begin
                state_d = SWR_RESET;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= SWR_RESET;
            powerState <= SWR_RESET;
            cpuReset <= 1'b1;
            mainClkEn <= 1'b1;
        end else begin
            state_q <= state_d;
            powerState <= state_d;
            // Watchdog resets only the core; the reset pin is input only
            cpuReset <= (state_d == SWR_RESET);
            mainClkEn <= (state_d != SWR_SLEEP);
        end
    end

    // Delay timer: restarts while the pin is held low, counts after release
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rstCnt_q <= DRT_LOAD;
        end else if (cause != SWR_C_NONE || (state_q == SWR_RESET && mclrLow)) begin
            rstCnt_q <= DRT_LOAD;
        end else if (state_q == SWR_RESET && rstCnt_q != 12'h000) begin
            rstCnt_q <= rstCnt_q - 12'h001;
        end
    end

    // Watchdog runs through sleep, so sleep is not a stop condition
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            watchdog_counter_q <= 23'h000000;
        end else if (wdtClr || baseDone) begin
            watchdog_counter_q <= 23'h000000;
        end else if (ctrl_q[`SWR_CT_WDT_EN]) begin
            watchdog_counter_q <= watchdog_counter_q + 23'h000001;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_q <= 7'h00;
        end else if (ctrl_q[`SWR_CT_PSA_WDT]) begin
            if (wdtClr || (baseDone && preDone)) begin
                pre_q <= 7'h00;
            end else if (baseDone) begin
                pre_q <= pre_q + 7'h01;
            end
        end
    end

    // Cause flags change only with a reset or a sleep entry
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            timeout_flag_n_q <= 1'b1;
            powerdown_flag_n_q <= 1'b1;
            pin_wake_flag_q <= 1'b0;
            comparator_wake_flag_q <= 1'b0;
        end else begin
            unique case (cause)
                SWR_C_NONE: begin
                    if (sleepGo) begin
                        timeout_flag_n_q <= 1'b1;
                        powerdown_flag_n_q <= 1'b0;
                    end
                end
                SWR_C_EXTERNAL_RESET_PIN_N: begin
                    pin_wake_flag_q <= 1'b0;
                    comparator_wake_flag_q <= 1'b0;
                    if (state_q == SWR_SLEEP) begin
                        timeout_flag_n_q <= 1'b1;
                        powerdown_flag_n_q <= 1'b0;
                    end
                end
                SWR_C_WDT: begin
                    timeout_flag_n_q <= 1'b0;
                    pin_wake_flag_q <= 1'b0;
                    comparator_wake_flag_q <= 1'b0;
                    if (state_q == SWR_SLEEP) begin
                        powerdown_flag_n_q <= 1'b0;
                    end
                end
                SWR_C_PIN: begin
                    pin_wake_flag_q <= 1'b1;
                    comparator_wake_flag_q <= 1'b0;
                    timeout_flag_n_q <= 1'b1;
                    powerdown_flag_n_q <= 1'b0;
                end
                SWR_C_CMP: begin
                    comparator_wake_flag_q <= 1'b1;
                    pin_wake_flag_q <= 1'b0;
                    timeout_flag_n_q <= 1'b1;
                    powerdown_flag_n_q <= 1'b0;
                end
                default: begin
                    pin_wake_flag_q <= pin_wake_flag_q;
                end
            endcase
        end
    end

    // Wake compare references; a wake does not refresh them
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinRef_q <= 3'h0;
            cmpRef_q <= 1'b0;
        end else begin
            if (state_q == SWR_RUN && portAccess) begin
                pinRef_q <= pinsNow;
            end
            if (sleepGo) begin
                cmpRef_q <= cmpNow;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= `SWR_CTRL_RST;
        end else if (wrCtrl) begin
            ctrl_q <= regWrData;
        end
    end

    // Port drive is frozen outside run so sleep keeps the pins as they were
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_q <= `SWR_PORT_RST;
            portOut <= 3'h0;
            portOeN <= 3'h7;
        end else begin
            if (wrPort && state_q == SWR_RUN) begin
                port_q <= regWrData;
                portOut <= regWrData[2:0];
                portOeN <= regWrData[6:4];
            end
        end
    end

    // Sticky events; a set in the clear cycle survives
    always_comb begin
        irqStat_d = irqStat_q;
        if (wrIrqClr) begin
            irqStat_d = irqStat_q & ~regWrData[2:0];
        end
        if (state_q == SWR_SLEEP && cause != SWR_C_NONE) begin
            irqStat_d[`SWR_IRQ_WAKE] = 1'b1;
        end
        if (cause == SWR_C_WDT) begin
            irqStat_d[`SWR_IRQ_WDT] = 1'b1;
        end
        if (cause == SWR_C_EXTERNAL_RESET_PIN_N) begin
            irqStat_d[`SWR_IRQ_EXTERNAL_RESET_PIN_N] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqStat_q <= 3'h0;
            irqEn_q <= `SWR_IRQ_EN_RST;
            irq <= 1'b0;
        end else begin
            irqStat_q <= irqStat_d;
            if (wrIrqEn) begin
                irqEn_q <= regWrData[2:0];
                irq <= |(irqStat_d & regWrData[2:0]);
            end else begin
                irq <= |(irqStat_d & irqEn_q);
            end
        end
    end

    // Unmapped and write-only offsets read as zero
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdData <= 8'h00;
        end else if (!regRd) begin
            regRdData <= 8'h00;
        end else if (hit(regAddr, `SWR_OFF_STATUS)) begin
            regRdData <= {pin_wake_flag_q, comparator_wake_flag_q, 1'b0,
                          timeout_flag_n_q, powerdown_flag_n_q, 3'h0};
        end else if (hit(regAddr, `SWR_OFF_CTRL)) begin
            regRdData <= ctrl_q;
        end else if (hit(regAddr, `SWR_OFF_PORT)) begin
            regRdData <= {port_q[7:4], 1'b0, port_q[2:0]};
        end else if (hit(regAddr, `SWR_OFF_IRQ_STAT)) begin
            regRdData <= {5'h00, irqStat_q};
        end else if (hit(regAddr, `SWR_OFF_IRQ_EN)) begin
            regRdData <= {5'h00, irqEn_q};
        end else begin
            regRdData <= 8'h00;
        end
    end

endmodule

// ### bench/swr_sleep_wake_monitor.sv
// Port-level checker for the sleep/wake block
`timescale 1ns/1ns
`include "swr_cfg.svh"
module swr_sleep_wake_monitor #(
    parameter int unsigned WDT_PERIOD_CYC = 16
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic regRd,
    input wire logic [`SWR_DATA_W-1:0] regRdData,
    input wire logic sleepExec,
    input wire logic [2:0] portOut,
    input wire logic [2:0] portOeN,
    input wire logic cpuReset,
    input wire logic mainClkEn,
    input wire swr_pkg::swr_state_t powerState
);
    import swr_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    AST_SLEEP_ENTRY: assert property (
        powerState == SWR_RUN && sleepExec && !cpuReset |=> powerState == SWR_SLEEP && !mainClkEn)
        else $error("sleep request not taken");
    AST_CLK_OFF: assert property (powerState == SWR_SLEEP |-> !mainClkEn && !cpuReset)
        else $error("main clock running in sleep");
    AST_WAKE_RESET: assert property (
        powerState == SWR_SLEEP ##1 powerState != SWR_SLEEP |-> powerState == SWR_RESET && cpuReset)
        else $error("sleep left without reset");
    AST_PORT_HOLD: assert property (
        powerState == SWR_SLEEP |=> $stable(portOut) && $stable(portOeN))
        else $error("port changed in sleep");
    AST_RST_CLK: assert property (powerState == SWR_RESET |-> mainClkEn && cpuReset)
        else $error("reset state without clock or core reset");
    AST_RST_HOLD: assert property ($rose(cpuReset) |-> cpuReset [*8])
        else $error("core reset too short");
    AST_SLEEP_REFUSE: assert property (
        powerState == SWR_RESET && sleepExec |=> powerState != SWR_SLEEP)
        else $error("sleep taken during reset");
    AST_RD_IDLE: assert property (!regRd |=> regRdData == 8'h00)
        else $error("read data outside read slot");
endmodule

// ### bench/swr_cpu_model.sv
// Core-side model: issues sleep and port accesses
`timescale 1ns/1ns
module swr_cpu_model (
    input wire logic ref_clk,
    output logic sleepExec,
    output logic portAccess
);
    initial begin
        sleepExec = 1'b0;
        portAccess = 1'b0;
    end

    // Re-reading the port refreshes the wake compare; skipping it re-wakes at once
    task automatic pulse_sleep(input logic reread);
        if (reread) begin
            @(posedge ref_clk);
            portAccess <= 1'b1;
            @(posedge ref_clk);
            portAccess <= 1'b0;
        end
        @(posedge ref_clk);
        sleepExec <= 1'b1;
        @(posedge ref_clk);
        sleepExec <= 1'b0;
    endtask
endmodule

// ### bench/tb_top.sv
// Testbench for the sleep/wake block
`timescale 1ns/1ns
`include "swr_cfg.svh"
module tb_top;
    import swr_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic external_reset_pin_n = 1'b1;
    logic port_pin0 = 1'b0;
    logic port_pin1 = 1'b0;
    logic port_pin3 = 1'b0;
    logic comparatorOut = 1'b0;
    logic [7:0] regRdData;
    logic [2:0] portOut;
    logic [2:0] portOeN;
    logic cpuReset;
    logic mainClkEn;
    logic irq;
    logic sleepExec;
    logic portAccess;
    swr_state_t powerState;
    int fails = 0;
    int n_tests = 0;
    int cnt;

    always #2 ref_clk = ~ref_clk;

    swr_sleep_wake #(.WDT_PERIOD_CYC(16)) u_dut (.ref_clk, .sys_rst, .regAddr, .regWrData,
        .regWr, .regRd, .regRdData, .sleepExec, .portAccess, .external_reset_pin_n,
        .port_pin0, .port_pin1, .port_pin3, .comparatorOut, .portOut, .portOeN, .cpuReset,
        .mainClkEn, .powerState, .irq);
    swr_cpu_model u_cpu (.ref_clk, .sleepExec, .portAccess);

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 check(what, exp, regRdData);
    endtask

    // Bounded wait for the core reset level; cnt keeps the cycles spent
    task automatic wait_rst(input logic lvl, input int lim);
        cnt = 0;
        while (cpuReset !== lvl && cnt < lim) begin
            @(posedge ref_clk);
            #1 cnt++;
        end
        check("cpuReset", {7'h00, lvl}, {7'h00, cpuReset});
    endtask

    task automatic stop_test;
        $display("counts fails=%0d n_tests=%0d", fails, n_tests);
        if (fails == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #200000;
        fails++;
        stop_test;
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd_chk("STATUS", 4'h0, 8'h18);
        rd_chk("CTRL", 4'h1, 8'hF3);
        rd_chk("PORT", 4'h2, 8'h70);
        rd_chk("unmapped", 4'hF, 8'h00);
        wait_rst(1'b0, 3000);
        wr(4'h1, 8'h0F);
        wait_rst(1'b1, 40);
        rd_chk("STATUS", 4'h0, 8'h08);
        u_cpu.pulse_sleep(1'b0);
        #1 check("powerState", 8'h02, {6'h00, powerState});
        wr(4'h1, 8'h0E);
        wr(4'h4, 8'h01);
        wait_rst(1'b0, 3000);
        // Port writes land only in run, so this one waits for the reset to end
        wr(4'h2, 8'h25);
        #1 check("port drive", 8'h25, {1'b0, portOeN, 1'b0, portOut});
        u_cpu.pulse_sleep(1'b1);
        rd_chk("STATUS", 4'h0, 8'h10);
        wr(4'h2, 8'h5A);
        rd_chk("PORT", 4'h2, 8'h25);
        port_pin0 <= 1'b1;
        wait_rst(1'b1, 20);
        rd_chk("STATUS", 4'h0, 8'h90);
        check("irq", 8'h01, {7'h00, irq});
        rd_chk("IRQ_STAT", 4'h3, 8'h03);
        wr(4'h5, 8'h07);
        rd_chk("IRQ_STAT", 4'h3, 8'h00);
        check("irq", 8'h00, {7'h00, irq});
        wait_rst(1'b0, 3000);
        u_cpu.pulse_sleep(1'b0);
        wait_rst(1'b1, 20);
        rd_chk("STATUS", 4'h0, 8'h90);
        wait_rst(1'b0, 3000);
        u_cpu.pulse_sleep(1'b1);
        comparatorOut <= 1'b1;
        wait_rst(1'b1, 20);
        rd_chk("STATUS", 4'h0, 8'h50);
        wait_rst(1'b0, 3000);
        external_reset_pin_n <= 1'b0;
        wait_rst(1'b1, 20);
        external_reset_pin_n <= 1'b1;
        rd_chk("STATUS", 4'h0, 8'h10);
        wait_rst(1'b0, 3000);
        u_cpu.pulse_sleep(1'b1);
        external_reset_pin_n <= 1'b0;
        wait_rst(1'b1, 20);
        external_reset_pin_n <= 1'b1;
        rd_chk("STATUS", 4'h0, 8'h10);
        // Pins 3 and 1 wake the block as pin 0 does
        wait_rst(1'b0, 3000);
        u_cpu.pulse_sleep(1'b1);
        port_pin3 <= 1'b1;
        wait_rst(1'b1, 20);
        rd_chk("STATUS", 4'h0, 8'h90);
        wait_rst(1'b0, 3000);
        u_cpu.pulse_sleep(1'b1);
        port_pin1 <= 1'b1;
        wait_rst(1'b1, 20);
        rd_chk("STATUS", 4'h0, 8'h90);
        wait_rst(1'b0, 3000);
        // Prescaled period 64; the run before sleep must not shorten the sleep span
        wr(4'h1, 8'h5F);
        repeat (40) @(posedge ref_clk);
        // Re-read first so the raised pins do not wake the block at once
        u_cpu.pulse_sleep(1'b1);
        wait_rst(1'b1, 100);
        check("wdt sleep span", 8'h01, {7'h00, cnt >= 56});
        rd_chk("STATUS", 4'h0, 8'h00);
        wr(4'h1, 8'h0E);
        stop_test;
    end
endmodule

bind swr_sleep_wake swr_sleep_wake_monitor #(.WDT_PERIOD_CYC(WDT_PERIOD_CYC)) u_mon (.ref_clk,
    .sys_rst, .regRd, .regRdData, .sleepExec, .portOut, .portOeN, .cpuReset, .mainClkEn,
    .powerState);
